// ==== jpc_pkg.sv ====
// package: register map, field layout, reset values and scaling for the loop control registers
package jpc_pkg;

    // register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 5;

    // register offsets
    localparam logic [7:0] ADDR_FEEDBACK_BYPASS_CTRL = 8'h03;
    localparam logic [7:0] ADDR_LOOP_BYPASS_CTRL = 8'h0A;
    localparam logic [7:0] ADDR_FIRST_LOOP_PUMP_CTRL = 8'h10;
    localparam logic [7:0] ADDR_OSC_OUTPUT_OFFSET_CTRL = 8'h11;
    localparam logic [7:0] ADDR_SECOND_LOOP_PUMP_CTRL = 8'h12;

    // reset values (force_mid_tuning set, both pump codes at 11000)
    localparam logic [7:0] RST_FEEDBACK_BYPASS_CTRL = 8'h00;
    localparam logic [7:0] RST_LOOP_BYPASS_CTRL = 8'h00;
    localparam logic [7:0] RST_FIRST_LOOP_PUMP_CTRL = 8'h58;
    localparam logic [7:0] RST_OSC_OUTPUT_OFFSET_CTRL = 8'h00;
    localparam logic [7:0] RST_SECOND_LOOP_PUMP_CTRL = 8'h18;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] MASK_FEEDBACK_BYPASS_CTRL = 8'h01;
    localparam logic [7:0] MASK_LOOP_BYPASS_CTRL = 8'h01;
    localparam logic [7:0] MASK_FIRST_LOOP_PUMP_CTRL = 8'hDF;
    localparam logic [7:0] MASK_OSC_OUTPUT_OFFSET_CTRL = 8'hFF;
    localparam logic [7:0] MASK_SECOND_LOOP_PUMP_CTRL = 8'h7F;

    // tables indexed by register slot
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{ADDR_FEEDBACK_BYPASS_CTRL,
        ADDR_LOOP_BYPASS_CTRL, ADDR_FIRST_LOOP_PUMP_CTRL, ADDR_OSC_OUTPUT_OFFSET_CTRL,
        ADDR_SECOND_LOOP_PUMP_CTRL};
    localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_FEEDBACK_BYPASS_CTRL,
        RST_LOOP_BYPASS_CTRL, RST_FIRST_LOOP_PUMP_CTRL, RST_OSC_OUTPUT_OFFSET_CTRL,
        RST_SECOND_LOOP_PUMP_CTRL};
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{MASK_FEEDBACK_BYPASS_CTRL,
        MASK_LOOP_BYPASS_CTRL, MASK_FIRST_LOOP_PUMP_CTRL, MASK_OSC_OUTPUT_OFFSET_CTRL,
        MASK_SECOND_LOOP_PUMP_CTRL};
    localparam int unsigned SLOT_FEEDBACK = 0;
    localparam int unsigned SLOT_LOOP = 1;
    localparam int unsigned SLOT_PUMP1 = 2;
    localparam int unsigned SLOT_OSC = 3;
    localparam int unsigned SLOT_PUMP2 = 4;

    // field positions
    localparam int unsigned BIT_FEEDBACK_BYPASS = 0;
    localparam int unsigned BIT_LOOP_BYPASS = 0;
    localparam int unsigned BIT_TUNING_POLARITY = 7;
    localparam int unsigned BIT_FORCE_MID_TUNING = 6;
    localparam int unsigned PUMP_LSB = 0;
    localparam int unsigned PUMP_W = 5;
    localparam int unsigned BIT_OSC_BUFFER_POWER = 7;
    localparam int unsigned BIT_OSC_BUFFER_FORMAT = 6;
    localparam int unsigned BIT_PHASE_OFFSET_ENABLE = 5;
    localparam int unsigned OFFSET_LSB = 0;
    localparam int unsigned OFFSET_W = 5;
    localparam int unsigned AMP_LSB = 5;
    localparam int unsigned AMP_W = 2;

    // scaling: pump steps in microamps, offset step 0.9 degree in millidegrees
    localparam int unsigned PUMP1_STEP_UA = 50;
    localparam int unsigned PUMP2_STEP_UA = 200;
    localparam int unsigned OFFSET_STEP_MDEG = 900;

    // feedback divider limits and reset ratio
    localparam int unsigned DIV1_W = 12;
    localparam int unsigned DIV2_W = 9;
    localparam int unsigned DIV1_MIN = 1;
    localparam int unsigned DIV2_MIN = 4;
    localparam int unsigned DIV1_RESET = 3072;
    localparam int unsigned DIV2_RESET = 96;
    localparam int unsigned RATIO_W = DIV1_W + DIV2_W;

    typedef struct packed {
        logic feedback_bypass;
        logic loop_enable;
        logic tuning_polarity;
        logic force_mid_tuning;
        logic [PUMP_W-1:0] first_pump_current;
        logic [PUMP_W-1:0] second_pump_current;
        logic osc_buffer_power;
        logic osc_buffer_format;
        logic [AMP_W-1:0] osc_buffer_amplitude;
        logic phase_offset_enable;
        logic [OFFSET_W-1:0] phase_offset_code;
    } jpc_cfg_t;

    typedef struct packed {
        logic [10:0] first_pump_ua;
        logic [12:0] second_pump_ua;
        logic [14:0] phase_offset_mdeg;
        logic [RATIO_W-1:0] feedback_ratio;
    } jpc_analog_t;

endpackage

// ==== jpc_cfg_reg.sv ====
// one 8-bit configuration register with a write mask for reserved bits
`timescale 1ns/1ns
`default_nettype none
module jpc_cfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // write side
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    // contents
    output logic [7:0] q_o
);
    logic [7:0] q_reg;
    logic [7:0] q_next;

    always_comb begin
        q_next = q_reg;
        if (wr_i) begin
            q_next = wdata_i & WR_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_reg <= RESET_VAL & WR_MASK;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule
`default_nettype wire

// ==== jpc_ctrl.sv ====
// control register group for the two-stage loop: register port and decoded controls
//
// Notes on behaviour
// - feedback bypass clear uses first divider only; set uses product of both
// - loop bypass set disables and routes around the first loop; reset enabled
// - tuning polarity clear is positive, set is negative
// - force mid tuning resets to one; software clears it so the loop locks
// - first pump current is (code plus one) times step; resets to 11000
// - oscillator buffer output powered down when clear (reset), up when set
// - oscillator buffer format: clear differential low voltage, set emitter coupled
// - offset enable applies the offset field to the phase detector, else none
// - offset scales linearly in 0.9 degree steps, max code 31, resets zero
// - second pump current is (code plus one) times step; resets to 11000
// - second divider range 4 to 511, first divider range 1 to 4095
`timescale 1ns/1ns
`default_nettype none
module jpc_ctrl
    import jpc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port behind the serial configuration interface
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_ack_o,
    // divider values held in the divider register group
    input wire logic [DIV1_W-1:0] first_feedback_divider_i,
    input wire logic [DIV2_W-1:0] second_feedback_divider_i,
    // decoded controls towards the analog loops
    output jpc_cfg_t cfg_o,
    output jpc_analog_t analog_o
);
    logic [7:0] regs [NUM_REGS];
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    jpc_cfg_t cfg_reg;
    jpc_cfg_t cfg_next;
    jpc_analog_t analog_reg;
    jpc_analog_t analog_next;
    logic [DIV1_W-1:0] div1_c;
    logic [DIV2_W-1:0] div2_c;

    // registers; the write mask keeps reserved bits at zero
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_regs
        jpc_cfg_reg #(
            .RESET_VAL(REG_RST[i]),
            .WR_MASK(REG_MASK[i])
        ) u_reg (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .wr_i(reg_wr_i && (reg_addr_i == REG_ADDR[i])),
            .wdata_i(reg_wdata_i),
            .q_o(regs[i])
        );
    end

    // read path: answer one cycle after the strobe, unmapped addresses read zero
    always_comb begin
        rdata_next = rdata_reg;
        ack_next = reg_rd_i;
        if (reg_rd_i) begin
            if (reg_addr_i == ADDR_FEEDBACK_BYPASS_CTRL) begin
                rdata_next = regs[SLOT_FEEDBACK];
            end else if (reg_addr_i == ADDR_LOOP_BYPASS_CTRL) begin
                rdata_next = regs[SLOT_LOOP];
            end else if (reg_addr_i == ADDR_FIRST_LOOP_PUMP_CTRL) begin
                rdata_next = regs[SLOT_PUMP1];
            end else if (reg_addr_i == ADDR_OSC_OUTPUT_OFFSET_CTRL) begin
                rdata_next = regs[SLOT_OSC];
            end else if (reg_addr_i == ADDR_SECOND_LOOP_PUMP_CTRL) begin
                rdata_next = regs[SLOT_PUMP2];
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    // out-of-range divider codes are pinned to that divider's lowest legal value
    always_comb begin
        div1_c = first_feedback_divider_i;
        div2_c = second_feedback_divider_i;
        if (first_feedback_divider_i < DIV1_W'(DIV1_MIN)) begin
            div1_c = DIV1_W'(DIV1_MIN);
        end
        if (second_feedback_divider_i < DIV2_W'(DIV2_MIN)) begin
            div2_c = DIV2_W'(DIV2_MIN);
        end
    end

    // field decode; outputs are registered so the loops see glitch-free controls
    always_comb begin
        cfg_next.feedback_bypass = regs[SLOT_FEEDBACK][BIT_FEEDBACK_BYPASS];
        cfg_next.loop_enable = !regs[SLOT_LOOP][BIT_LOOP_BYPASS];
        cfg_next.tuning_polarity = regs[SLOT_PUMP1][BIT_TUNING_POLARITY];
        cfg_next.force_mid_tuning = regs[SLOT_PUMP1][BIT_FORCE_MID_TUNING];
        cfg_next.first_pump_current = regs[SLOT_PUMP1][PUMP_LSB +: PUMP_W];
        cfg_next.second_pump_current = regs[SLOT_PUMP2][PUMP_LSB +: PUMP_W];
        cfg_next.osc_buffer_power = regs[SLOT_OSC][BIT_OSC_BUFFER_POWER];
        cfg_next.osc_buffer_format = regs[SLOT_OSC][BIT_OSC_BUFFER_FORMAT];
        cfg_next.osc_buffer_amplitude = regs[SLOT_PUMP2][AMP_LSB +: AMP_W];
        cfg_next.phase_offset_enable = regs[SLOT_OSC][BIT_PHASE_OFFSET_ENABLE];
        // the detector sees no offset current at all while disabled
        cfg_next.phase_offset_code = '0;
        if (regs[SLOT_OSC][BIT_PHASE_OFFSET_ENABLE]) begin
            cfg_next.phase_offset_code = regs[SLOT_OSC][OFFSET_LSB +: OFFSET_W];
        end
    end

    // scaled values for monitoring; pump code 0 still gives one step
    always_comb begin
        analog_next.first_pump_ua = (11'(cfg_next.first_pump_current) + 11'h001)
            * 11'(PUMP1_STEP_UA);
        analog_next.second_pump_ua = (13'(cfg_next.second_pump_current) + 13'h0001)
            * 13'(PUMP2_STEP_UA);
        analog_next.phase_offset_mdeg = 15'(cfg_next.phase_offset_code)
            * 15'(OFFSET_STEP_MDEG);
        if (cfg_next.feedback_bypass) begin
            analog_next.feedback_ratio = RATIO_W'(div1_c) * RATIO_W'(div2_c);
        end else begin
            analog_next.feedback_ratio = RATIO_W'(div1_c);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_reg <= '0;
            cfg_reg.loop_enable <= 1'b1;
            cfg_reg.force_mid_tuning <= 1'b1;
            cfg_reg.first_pump_current <= RST_FIRST_LOOP_PUMP_CTRL[PUMP_W-1:0];
            cfg_reg.second_pump_current <= RST_SECOND_LOOP_PUMP_CTRL[PUMP_W-1:0];
            analog_reg.first_pump_ua <= 11'((PUMP1_STEP_UA
                * (RST_FIRST_LOOP_PUMP_CTRL[PUMP_W-1:0] + 1)));
            analog_reg.second_pump_ua <= 13'((PUMP2_STEP_UA
                * (RST_SECOND_LOOP_PUMP_CTRL[PUMP_W-1:0] + 1)));
            analog_reg.phase_offset_mdeg <= '0;
            analog_reg.feedback_ratio <= RATIO_W'(DIV1_RESET);
        end else begin
            cfg_reg <= cfg_next;
            analog_reg <= analog_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_ack_o = ack_reg;
    assign cfg_o = cfg_reg;
    assign analog_o = analog_reg;

    // checks
    a_fb_ratio_sel: assert property (@(posedge clk_i) disable iff (srst_i)
        !$past(srst_i) |-> (analog_o.feedback_ratio == (cfg_o.feedback_bypass
        ? RATIO_W'($past(div1_c)) * RATIO_W'($past(div2_c)) : RATIO_W'($past(div1_c)))))
        else $error("feedback ratio does not follow bypass bit");
    a_loop_bypass_write: assert property (@(posedge clk_i) disable iff (srst_i)
        (reg_wr_i && reg_addr_i == ADDR_LOOP_BYPASS_CTRL)
        |-> ##2 (cfg_o.loop_enable == !$past(reg_wdata_i[BIT_LOOP_BYPASS], 2)))
        else $error("loop enable not inverse of written bypass bit");
    a_polarity_write: assert property (@(posedge clk_i) disable iff (srst_i)
        (reg_wr_i && reg_addr_i == ADDR_FIRST_LOOP_PUMP_CTRL)
        |-> ##2 (cfg_o.tuning_polarity == $past(reg_wdata_i[BIT_TUNING_POLARITY], 2)))
        else $error("tuning polarity not taken from write");
    a_reset_defaults: assert property (@(posedge clk_i)
        srst_i |=> (cfg_o.force_mid_tuning && cfg_o.loop_enable
        && cfg_o.first_pump_current == 5'h18 && cfg_o.second_pump_current == 5'h18
        && !cfg_o.osc_buffer_power && !cfg_o.osc_buffer_format))
        else $error("control outputs wrong after reset");
    a_pump1_scale: assert property (@(posedge clk_i) disable iff (srst_i)
        analog_o.first_pump_ua == (11'(cfg_o.first_pump_current) + 11'h001) * 11'h032)
        else $error("first pump current scaling wrong");
    a_osc_power_write: assert property (@(posedge clk_i) disable iff (srst_i)
        (reg_wr_i && reg_addr_i == ADDR_OSC_OUTPUT_OFFSET_CTRL)
        |-> ##2 (cfg_o.osc_buffer_power == $past(reg_wdata_i[BIT_OSC_BUFFER_POWER], 2)
        && cfg_o.osc_buffer_format == $past(reg_wdata_i[BIT_OSC_BUFFER_FORMAT], 2)))
        else $error("oscillator buffer power or format not taken from write");
    a_offset_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        !cfg_o.phase_offset_enable |-> (cfg_o.phase_offset_code == '0
        && analog_o.phase_offset_mdeg == '0))
        else $error("offset applied while disabled");
    a_offset_scale: assert property (@(posedge clk_i) disable iff (srst_i)
        analog_o.phase_offset_mdeg == 15'(cfg_o.phase_offset_code) * 15'h0384)
        else $error("phase offset scaling wrong");
    a_pump2_scale: assert property (@(posedge clk_i) disable iff (srst_i)
        analog_o.second_pump_ua == (13'(cfg_o.second_pump_current) + 13'h0001) * 13'h00C8)
        else $error("second pump current scaling wrong");
    a_div_floor: assert property (@(posedge clk_i) disable iff (srst_i)
        (second_feedback_divider_i < 9'h004 && first_feedback_divider_i != 12'h000)
        |=> (!cfg_o.feedback_bypass || analog_o.feedback_ratio
        == 21'($past(first_feedback_divider_i)) * 21'h000004))
        else $error("second divider below floor used");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (reg_rd_i && reg_addr_i == ADDR_LOOP_BYPASS_CTRL)
        |=> (reg_ack_o && reg_rdata_o[7:1] == 7'h00))
        else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// ==== jpc_ctrl_test.sv ====
// self-checking bench for the loop control register group
`timescale 1ns/1ns
`default_nettype none
module jpc_ctrl_test;
    import jpc_pkg::*;

    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic reg_ack_o;
    logic [DIV1_W-1:0] first_feedback_divider = 12'hC00;
    logic [DIV2_W-1:0] second_feedback_divider = 9'h060;
    jpc_cfg_t cfg_o;
    jpc_analog_t analog_o;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] rst_exp [NUM_REGS] = '{8'h00, 8'h00, 8'h58, 8'h00, 8'h18};

    always #2 clk_i = ~clk_i;

    jpc_ctrl dut_u (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o),
        .first_feedback_divider_i(first_feedback_divider),
        .second_feedback_divider_i(second_feedback_divider),
        .cfg_o(cfg_o),
        .analog_o(analog_o)
    );

    task automatic complete_run;
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // decoded outputs lag the taking edge by one cycle; two idle cycles wait them out here
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = addr;
        reg_wdata_i = data;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp, input string what);
        int i;
        @(negedge clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = addr;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        i = 0;
        while (reg_ack_o !== 1'b1 && i < 4) begin
            @(negedge clk_i);
            i++;
        end
        if (i == 4) begin
            n_errors++;
            $display("ERROR reg_ack_o expected 1 seen timeout");
            complete_run();
        end else begin
            check("read answer latency", 0, i);
            check(what, exp, reg_rdata_o);
        end
    endtask

    task automatic osc_case(input logic [7:0] data, input logic pwr, input logic fmt,
            input logic en, input logic [4:0] code, input int mdeg);
        reg_write(ADDR_OSC_OUTPUT_OFFSET_CTRL, data);
        reg_read(ADDR_OSC_OUTPUT_OFFSET_CTRL, data, "osc_output_offset_ctrl");
        check("osc_buffer_power", pwr, cfg_o.osc_buffer_power);
        check("osc_buffer_format", fmt, cfg_o.osc_buffer_format);
        check("phase_offset_enable", en, cfg_o.phase_offset_enable);
        check("phase_offset_code", code, cfg_o.phase_offset_code);
        check("phase_offset_mdeg", mdeg, analog_o.phase_offset_mdeg);
    endtask

    task automatic set_dividers(input logic [11:0] d1, input logic [8:0] d2);
        @(negedge clk_i);
        first_feedback_divider = d1;
        second_feedback_divider = d2;
        repeat (2) @(negedge clk_i);
    endtask

    initial begin
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        for (int s = 0; s < NUM_REGS; s++) begin
            reg_read(REG_ADDR[s], rst_exp[s], "reset value");
        end
        check("loop_enable", 1, cfg_o.loop_enable);
        check("force_mid_tuning", 1, cfg_o.force_mid_tuning);
        check("osc_buffer_power", 0, cfg_o.osc_buffer_power);
        check("osc_buffer_format", 0, cfg_o.osc_buffer_format);
        check("first_pump_ua", 1250, analog_o.first_pump_ua);
        check("second_pump_ua", 5000, analog_o.second_pump_ua);
        check("first_pump_current", 5'h18, cfg_o.first_pump_current);
        check("second_pump_current", 5'h18, cfg_o.second_pump_current);
        check("phase_offset_mdeg", 0, analog_o.phase_offset_mdeg);
        check("feedback_ratio", 3072, analog_o.feedback_ratio);
        // feedback path: first divider alone, then the product
        set_dividers(12'h005, 9'h007);
        check("feedback_ratio", 5, analog_o.feedback_ratio);
        reg_write(ADDR_FEEDBACK_BYPASS_CTRL, 8'hFF);
        reg_read(ADDR_FEEDBACK_BYPASS_CTRL, 8'h01, "feedback_bypass_ctrl");
        check("feedback_bypass", 1, cfg_o.feedback_bypass);
        check("feedback_ratio", 35, analog_o.feedback_ratio);
        set_dividers(12'hFFF, 9'h1FF);
        check("feedback_ratio", 2092545, analog_o.feedback_ratio);
        // dividers below range pinned to 1 and 4: both low, then the second alone
        set_dividers(12'h000, 9'h002);
        check("feedback_ratio", 4, analog_o.feedback_ratio);
        set_dividers(12'h005, 9'h003);
        check("feedback_ratio", 20, analog_o.feedback_ratio);
        reg_write(ADDR_FEEDBACK_BYPASS_CTRL, 8'h00);
        check("feedback_ratio", 5, analog_o.feedback_ratio);
        // loop bypass
        reg_write(ADDR_LOOP_BYPASS_CTRL, 8'hFF);
        reg_read(ADDR_LOOP_BYPASS_CTRL, 8'h01, "loop_bypass_ctrl");
        check("loop_enable", 0, cfg_o.loop_enable);
        reg_write(ADDR_LOOP_BYPASS_CTRL, 8'h00);
        check("loop_enable", 1, cfg_o.loop_enable);
        // first loop pump, polarity and forced mid tuning
        reg_write(ADDR_FIRST_LOOP_PUMP_CTRL, 8'hFF);
        reg_read(ADDR_FIRST_LOOP_PUMP_CTRL, 8'hDF, "first_loop_pump_ctrl");
        check("tuning_polarity", 1, cfg_o.tuning_polarity);
        check("first_pump_ua", 1600, analog_o.first_pump_ua);
        check("first_pump_current", 5'h1F, cfg_o.first_pump_current);
        // software releases the forced mid tuning after startup
        reg_write(ADDR_FIRST_LOOP_PUMP_CTRL, 8'h00);
        check("tuning_polarity", 0, cfg_o.tuning_polarity);
        check("force_mid_tuning", 0, cfg_o.force_mid_tuning);
        check("first_pump_ua", 50, analog_o.first_pump_ua);
        // oscillator buffer and static offset
        osc_case(8'hA5, 1'b1, 1'b0, 1'b1, 5'h05, 4500);
        osc_case(8'h1F, 1'b0, 1'b0, 1'b0, 5'h00, 0);
        osc_case(8'h7F, 1'b0, 1'b1, 1'b1, 5'h1F, 27900);
        // second loop pump and amplitude code
        reg_write(ADDR_SECOND_LOOP_PUMP_CTRL, 8'hFF);
        reg_read(ADDR_SECOND_LOOP_PUMP_CTRL, 8'h7F, "second_loop_pump_ctrl");
        check("second_pump_ua", 6400, analog_o.second_pump_ua);
        check("osc_buffer_amplitude", 3, cfg_o.osc_buffer_amplitude);
        reg_write(ADDR_SECOND_LOOP_PUMP_CTRL, 8'h40);
        check("second_pump_ua", 200, analog_o.second_pump_ua);
        check("second_pump_current", 0, cfg_o.second_pump_current);
        // unmapped place: write ignored, reads zero, neighbours untouched
        reg_write(8'h05, 8'hFF);
        reg_read(8'h05, 8'h00, "unmapped read");
        reg_read(ADDR_LOOP_BYPASS_CTRL, 8'h00, "loop_bypass_ctrl");
        reg_read(ADDR_OSC_OUTPUT_OFFSET_CTRL, 8'h7F, "osc_output_offset_ctrl");
        // reset again from a changed state: every control returns to its default
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        srst_i = 1'b0;
        for (int s = 0; s < NUM_REGS; s++) begin
            reg_read(REG_ADDR[s], rst_exp[s], "reset value");
        end
        check("force_mid_tuning", 1, cfg_o.force_mid_tuning);
        check("loop_enable", 1, cfg_o.loop_enable);
        check("tuning_polarity", 0, cfg_o.tuning_polarity);
        check("second_pump_current", 5'h18, cfg_o.second_pump_current);
        check("second_pump_ua", 5000, analog_o.second_pump_ua);
        check("first_pump_ua", 1250, analog_o.first_pump_ua);
        check("osc_buffer_format", 0, cfg_o.osc_buffer_format);
        check("phase_offset_mdeg", 0, analog_o.phase_offset_mdeg);
        complete_run();
    end
endmodule
`default_nettype wire
